// ===== core/ae_awb_window_regs.svh
/*
  Register offsets, reset values, field positions and scaling constants
  for the exposure and white-balance window configuration slice.
  Assumes inclusion by bare name from the design file.
*/
`ifndef AE_AWB_WINDOW_REGS_SVH
`define AE_AWB_WINDOW_REGS_SVH

`define CENTRE_VERT_OFFSET 10'h22c
`define AWB_BOUNDS_OFFSET 10'h22d
`define AE_TARGET_OFFSET 10'h22e

`define CENTRE_VERT_RESET 16'h6020
`define AWB_BOUNDS_RESET 16'hf0a0
`define AE_TARGET_RESET 16'h0c4a

`define HI_BYTE_MSB 15
`define HI_BYTE_LSB 8
`define LO_BYTE_MSB 7
`define LO_BYTE_LSB 0
`define AWB_BOTTOM_MSB 15
`define AWB_BOTTOM_LSB 12
`define AWB_TOP_MSB 11
`define AWB_TOP_LSB 8
`define AWB_RIGHT_MSB 7
`define AWB_RIGHT_LSB 4
`define AWB_LEFT_MSB 3
`define AWB_LEFT_LSB 0

`define H_BLOCKS 10
`define V_BLOCKS 16
`define H_UNIT_BLOCKS 2
`define FRAC_FULL_SCALE 128

`endif

// ===== core/ae_awb_window_pkg.sv
/*
  Types for the exposure and white-balance window configuration slice.
  Needs no constants header; all widths are written out in full.
*/
`default_nettype none

package ae_awb_window_pkg;

  typedef struct packed {
    logic [15:0] centre_vert;
    logic [15:0] awb_bounds;
    logic [15:0] ae_target;
  } cfg_regs_t;

  typedef struct packed {
    logic [11:0] left;
    logic [11:0] right;
    logic [11:0] top;
    logic [11:0] bottom;
  } pix_window_t;

  typedef struct packed {
    cfg_regs_t shadow;
    cfg_regs_t active;
    pix_window_t awb_win;
    pix_window_t centre_win;
    logic [15:0] rd_data;
    logic adjust;
    logic in_band;
  } state_t;

endpackage

`default_nettype wire

// ===== core/ae_awb_window_config.sv
/*
  Exposure centre-window, white-balance window and luma-target registers,
  with pixel-limit scaling and stability-band decision.
  Assumes a register port on clk, frame_start from pixel logic on clk,
  and an image size that is stable within a frame.
*/
// How it works
// - Centre vertical: bottom 15:8, top 7:0, 128=bottom
// - Centre window used only during backlight compensation
// - Horizontal block is image width over ten
// - Vertical block is image height over sixteen
// - White-balance bottom 15:12, top 11:8
// - White-balance right 7:4, left 3:0, two-block units
// - Pixel limits rescale when resolution changes
// - No adjustment while luma inside stability band
// - Band centred on target, half-size in 15:8
// - Luma target sits in bits 7:0
`include "ae_awb_window_regs.svh"
`default_nettype none

module ae_awb_window_config
  import ae_awb_window_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [9:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic frame_start,
  input wire logic backlight_comp,
  input wire logic [11:0] image_width,
  input wire logic [11:0] image_height,
  input wire logic [7:0] measured_luma,
  input wire logic luma_valid,
  output logic [11:0] ae_win_top,
  output logic [11:0] ae_win_bottom,
  output logic ae_centre_sel,
  output logic [11:0] awb_win_left,
  output logic [11:0] awb_win_right,
  output logic [11:0] awb_win_top,
  output logic [11:0] awb_win_bottom,
  output logic [7:0] ae_target_luma,
  output logic [7:0] ae_band_half,
  output logic ae_adjust,
  output logic ae_in_band
);

  state_t state_reg;
  state_t state_next;

  ////////////////////////////////////////////////////////////////////////////
  // Scaling helpers

  // Fraction of 128 applied to a pixel extent; widened to avoid overflow
  function automatic logic [11:0] frac_scale(input logic [7:0] frac, input logic [11:0] extent);
    logic [19:0] prod;
    prod = 20'(frac) * 20'(extent);
    frac_scale = 12'(prod / 20'(`FRAC_FULL_SCALE));
  endfunction

  // Block count times block size; block is extent over divisor
  function automatic logic [11:0] block_scale(input logic [4:0] blocks, input logic [11:0] extent,
                                              input logic [4:0] divisor);
    logic [16:0] prod;
    logic [16:0] lim;
    prod = 17'(blocks) * 17'(extent);
    lim = prod / 17'(divisor);
    // Clamp so an oversized bound stays on the image
    block_scale = (lim > 17'(extent)) ? extent : 12'(lim);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Field extraction from the frame-stable copy

  // Only the active copy feeds the engines, so a half-written set never shows
  logic [7:0] centre_top_frac;
  logic [7:0] centre_bottom_frac;
  logic [4:0] awb_top_blocks;
  logic [4:0] awb_bottom_blocks;
  logic [4:0] awb_left_blocks;
  logic [4:0] awb_right_blocks;
  logic [7:0] target_luma;
  logic [7:0] band_half;

  assign centre_top_frac = state_reg.active.centre_vert[`LO_BYTE_MSB:`LO_BYTE_LSB];
  assign centre_bottom_frac = state_reg.active.centre_vert[`HI_BYTE_MSB:`HI_BYTE_LSB];
  assign awb_top_blocks = {1'b0, state_reg.active.awb_bounds[`AWB_TOP_MSB:`AWB_TOP_LSB]};
  assign awb_bottom_blocks = {1'b0, state_reg.active.awb_bounds[`AWB_BOTTOM_MSB:`AWB_BOTTOM_LSB]};
  // Horizontal fields count pairs of blocks; largest product 30 fits five bits
  assign awb_left_blocks = 5'({1'b0, state_reg.active.awb_bounds[`AWB_LEFT_MSB:`AWB_LEFT_LSB]}
                              * 5'(`H_UNIT_BLOCKS));
  assign awb_right_blocks = 5'({1'b0, state_reg.active.awb_bounds[`AWB_RIGHT_MSB:`AWB_RIGHT_LSB]}
                               * 5'(`H_UNIT_BLOCKS));
  assign target_luma = state_reg.active.ae_target[`LO_BYTE_MSB:`LO_BYTE_LSB];
  assign band_half = state_reg.active.ae_target[`HI_BYTE_MSB:`HI_BYTE_LSB];

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  logic [8:0] luma_diff;
  logic [7:0] luma_abs;

  always_comb begin
    state_next = state_reg;
    state_next.rd_data = 16'h0000;

    // Writes land in the shadow copy only
    if (reg_wr) begin
      unique case (reg_addr)
        `CENTRE_VERT_OFFSET: begin
          state_next.shadow.centre_vert = reg_wdata;
        end
        `AWB_BOUNDS_OFFSET: begin
          state_next.shadow.awb_bounds = reg_wdata;
        end
        `AE_TARGET_OFFSET: begin
          state_next.shadow.ae_target = reg_wdata;
        end
        default: begin
        end
      endcase
    end

    // Reads return what software wrote, unmapped reads zero
    if (reg_rd) begin
      unique case (reg_addr)
        `CENTRE_VERT_OFFSET: begin
          state_next.rd_data = state_reg.shadow.centre_vert;
        end
        `AWB_BOUNDS_OFFSET: begin
          state_next.rd_data = state_reg.shadow.awb_bounds;
        end
        `AE_TARGET_OFFSET: begin
          state_next.rd_data = state_reg.shadow.ae_target;
        end
        default: begin
          state_next.rd_data = 16'h0000;
        end
      endcase
    end

    // The active register copy changes only at frame_start
    if (frame_start) begin
      state_next.active = state_reg.shadow;
    end

    // Recomputed every cycle so a new size is followed at once
    state_next.centre_win.top = frac_scale(centre_top_frac, image_height);
    state_next.centre_win.bottom = frac_scale(centre_bottom_frac, image_height);
    state_next.centre_win.left = 12'h000;
    state_next.centre_win.right = image_width;

    state_next.awb_win.top = block_scale(awb_top_blocks, image_height, 5'(`V_BLOCKS));
    state_next.awb_win.bottom = block_scale(awb_bottom_blocks, image_height, 5'(`V_BLOCKS));
    state_next.awb_win.left = block_scale(awb_left_blocks, image_width, 5'(`H_BLOCKS));
    state_next.awb_win.right = block_scale(awb_right_blocks, image_width, 5'(`H_BLOCKS));

    // Unsigned distance from the target; nine bits keep the borrow
    luma_diff = {1'b0, measured_luma} - {1'b0, target_luma};
    luma_abs = luma_diff[8] ? 8'(-luma_diff) : luma_diff[7:0];
    if (luma_valid) begin
      state_next.in_band = luma_abs <= band_half;
      state_next.adjust = !(luma_abs <= band_half);
    end else begin
      state_next.adjust = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg.shadow.centre_vert <= `CENTRE_VERT_RESET;
      state_reg.shadow.awb_bounds <= `AWB_BOUNDS_RESET;
      state_reg.shadow.ae_target <= `AE_TARGET_RESET;
      state_reg.active.centre_vert <= `CENTRE_VERT_RESET;
      state_reg.active.awb_bounds <= `AWB_BOUNDS_RESET;
      state_reg.active.ae_target <= `AE_TARGET_RESET;
      state_reg.awb_win.left <= 12'h000;
      state_reg.awb_win.right <= 12'h000;
      state_reg.awb_win.top <= 12'h000;
      state_reg.awb_win.bottom <= 12'h000;
      state_reg.centre_win.left <= 12'h000;
      state_reg.centre_win.right <= 12'h000;
      state_reg.centre_win.top <= 12'h000;
      state_reg.centre_win.bottom <= 12'h000;
      state_reg.rd_data <= 16'h0000;
      state_reg.adjust <= 1'b0;
      state_reg.in_band <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flip-flops, the window mux registers included

  logic [11:0] ae_top_reg;
  logic [11:0] ae_bottom_reg;
  logic centre_sel_reg;

  // Normal window fallback is the full frame height
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ae_top_reg <= 12'h000;
      ae_bottom_reg <= 12'h000;
      centre_sel_reg <= 1'b0;
    end else begin
      centre_sel_reg <= backlight_comp;
      ae_top_reg <= backlight_comp ? state_next.centre_win.top : 12'h000;
      ae_bottom_reg <= backlight_comp ? state_next.centre_win.bottom : image_height;
    end
  end

  assign reg_rdata = state_reg.rd_data;
  assign ae_win_top = ae_top_reg;
  assign ae_win_bottom = ae_bottom_reg;
  assign ae_centre_sel = centre_sel_reg;
  assign awb_win_left = state_reg.awb_win.left;
  assign awb_win_right = state_reg.awb_win.right;
  assign awb_win_top = state_reg.awb_win.top;
  assign awb_win_bottom = state_reg.awb_win.bottom;
  assign ae_target_luma = state_reg.active.ae_target[`LO_BYTE_MSB:`LO_BYTE_LSB];
  assign ae_band_half = state_reg.active.ae_target[`HI_BYTE_MSB:`HI_BYTE_LSB];
  assign ae_adjust = state_reg.adjust;
  assign ae_in_band = state_reg.in_band;

endmodule

`default_nettype wire

// ===== sim/ae_awb_window_asserts.sv
/*
  Port checker for the window config slice.
  Assumes one clock, async active-high reset.
*/
`default_nettype none
module ae_awb_window_asserts (
  input wire logic clk,
  input wire logic reset,
  input wire logic [9:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic frame_start,
  input wire logic backlight_comp,
  input wire logic [11:0] image_width,
  input wire logic [11:0] image_height,
  input wire logic [7:0] measured_luma,
  input wire logic luma_valid,
  input wire logic [11:0] ae_win_top,
  input wire logic [11:0] ae_win_bottom,
  input wire logic ae_centre_sel,
  input wire logic [11:0] awb_win_left,
  input wire logic [11:0] awb_win_right,
  input wire logic [11:0] awb_win_top,
  input wire logic [11:0] awb_win_bottom,
  input wire logic [7:0] ae_target_luma,
  input wire logic [7:0] ae_band_half,
  input wire logic ae_adjust,
  input wire logic ae_in_band
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  logic [7:0] diff;
  // Unsigned distance, no sign bit needed
  assign diff = (measured_luma > ae_target_luma) ? measured_luma - ae_target_luma : ae_target_luma - measured_luma;
  ////////////////////////////////////////////////////////////////
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data not idle");
  a_read_unmapped: assert property (reg_rd && reg_addr > 10'h22e |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_adjust_out: assert property (luma_valid && !$past(frame_start) && diff > ae_band_half
    |=> ae_adjust && !ae_in_band) else $error("missing adjust");
  a_band_hold: assert property (luma_valid && !$past(frame_start) && diff <= ae_band_half
    |=> !ae_adjust && ae_in_band) else $error("adjust inside band");
  a_adjust_cause: assert property (!luma_valid |=> !ae_adjust && $stable(ae_in_band))
    else $error("decision without luma");
  a_target_hold: assert property (!frame_start |=> $stable({ae_target_luma, ae_band_half}))
    else $error("target moved mid frame");
  a_centre_off: assert property ((!backlight_comp && $stable(image_height))[*3]
    |-> ae_win_top == 12'h000 && ae_win_bottom == image_height) else $error("centre window leak");
  a_centre_sel: assert property (backlight_comp[*2] |-> ae_centre_sel)
    else $error("centre select lost");
  a_awb_hold: assert property ((!frame_start && $stable({image_width, image_height}))[*3]
    |-> $stable({awb_win_left, awb_win_right, awb_win_top, awb_win_bottom}))
    else $error("white balance window moved");
endmodule
bind ae_awb_window_config ae_awb_window_asserts u_chk (.clk, .reset, .reg_addr, .reg_rd, .reg_rdata,
  .frame_start, .backlight_comp, .image_width, .image_height, .measured_luma, .luma_valid, .ae_win_top,
  .ae_win_bottom, .ae_centre_sel, .awb_win_left, .awb_win_right, .awb_win_top, .awb_win_bottom,
  .ae_target_luma, .ae_band_half, .ae_adjust, .ae_in_band);
`default_nettype wire

// ===== sim/testbench.sv
/*
  Self-checking bench for the window config slice.
  Assumes the package and design are compiled first.
*/
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, frame_start = 0, backlight_comp = 0, luma_valid = 0;
  logic [9:0] reg_addr = 0;
  logic [15:0] reg_wdata = 0, reg_rdata, cv, awb, tgt;
  logic [11:0] image_width = 12'h280, image_height = 12'h1e0, ae_win_top, ae_win_bottom;
  logic [11:0] awb_win_left, awb_win_right, awb_win_top, awb_win_bottom, w, h;
  logic [7:0] measured_luma = 0, ae_target_luma, ae_band_half;
  logic ae_centre_sel, ae_adjust, ae_in_band;
  logic [31:0] seed = 32'h8073_1ddd;
  int fails = 0, checks = 0, cyc = 0;
  always #2 clk = ~clk;
  ae_awb_window_config u_dut (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .frame_start, .backlight_comp, .image_width, .image_height, .measured_luma, .luma_valid, .ae_win_top,
    .ae_win_bottom, .ae_centre_sel, .awb_win_left, .awb_win_right, .awb_win_top, .awb_win_bottom,
    .ae_target_luma, .ae_band_half, .ae_adjust, .ae_in_band);
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {1'b0, s[31:1]} ^ (s[0] ? 32'ha300_0000 : 32'h0000_0000);
  endfunction
  // Scale a block count to pixels, clamped to the extent
  function automatic logic [11:0] sc(input logic [31:0] n, d, m);
    logic [31:0] v;
    v = n * m / d;
    return (v > m) ? m[11:0] : v[11:0];
  endfunction
  task automatic chk(input logic [15:0] got, exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 0;
  endtask
  task automatic rd(input logic [9:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 0;
    #1 chk(reg_rdata, e);
  endtask
  task automatic luma(input logic [7:0] l);
    logic [7:0] d;
    @(posedge clk);
    luma_valid <= 1;
    measured_luma <= l;
    @(posedge clk);
    luma_valid <= 0;
    d = (l > tgt[7:0]) ? l - tgt[7:0] : tgt[7:0] - l;
    #1 chk({ae_adjust, ae_in_band}, {d > tgt[15:8], d <= tgt[15:8]});
  endtask
  task automatic frame();
    @(posedge clk);
    frame_start <= 1;
    @(posedge clk);
    frame_start <= 0;
    repeat (2) @(posedge clk);
    #1 chk({ae_band_half, ae_target_luma}, tgt);
    chk(awb_win_top, sc(awb[11:8], 16, h));
    chk(awb_win_bottom, sc(awb[15:12], 16, h));
    chk(awb_win_left, sc(2 * awb[3:0], 10, w));
    chk(awb_win_right, sc(2 * awb[7:4], 10, w));
    chk(ae_win_top, backlight_comp ? sc(cv[7:0], 128, h) : 12'h000);
    chk(ae_win_bottom, backlight_comp ? sc(cv[15:8], 128, h) : h);
    chk(ae_centre_sel, backlight_comp);
  endtask
  task automatic summarize();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // Ceiling well above the roughly 760 cycles the sequence needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      fails++;
      summarize();
    end
  end
  initial begin
    w = image_width;
    h = image_height;
    cv = 16'h6020;
    awb = 16'hf0a0;
    tgt = 16'h0c4a;
    repeat (12) @(posedge clk);
    reset <= 0;
    rd(10'h22c, cv);
    rd(10'h22d, awb);
    rd(10'h22e, tgt);
    rd(10'h22f, 16'h0000);
    frame();
    for (int i = 0; i < 40; i++) begin
      seed = nxt(seed);
      // Fractions kept within the frame; larger ones have no defined clamp
      cv = {1'b0, seed[6:0], 1'b0, seed[14:8]};
      awb = seed[31:16];
      seed = nxt(seed);
      tgt = (i < 4) ? {8'h00, seed[7:0]} : seed[15:0];
      w = 12'h040 + seed[25:16];
      h = 12'h040 + {3'b000, seed[30:26], 3'b000};
      wr(10'h22c, cv);
      wr(10'h22d, awb);
      wr(10'h22e, tgt);
      rd(10'h22d, awb);
      image_width <= w;
      image_height <= h;
      backlight_comp <= seed[31];
      frame();
      luma(tgt[7:0] + tgt[15:8]);
      luma(tgt[7:0] + tgt[15:8] + 8'h01);
      luma(seed[7:0] ^ seed[15:8]);
    end
    // Size change with no frame boundary must still rescale
    @(posedge clk);
    image_width <= 12'h3c0;
    w = 12'h3c0;
    repeat (3) @(posedge clk);
    #1 chk(awb_win_right, sc(2 * awb[7:4], 10, w));
    chk(awb_win_left, sc(2 * awb[3:0], 10, w));
    // Write beside a frame boundary waits for the next boundary
    @(posedge clk);
    reg_wr <= 1;
    reg_addr <= 10'h22e;
    reg_wdata <= 16'h0580;
    frame_start <= 1;
    @(posedge clk);
    reg_wr <= 0;
    frame_start <= 0;
    repeat (2) @(posedge clk);
    #1 chk({ae_band_half, ae_target_luma}, tgt);
    tgt = 16'h0580;
    frame();
    luma(8'h85);
    luma(8'h86);
    summarize();
  end
endmodule
`default_nettype wire
